// *** nced_dispatch.sv ***
// Function decoder and nanocode next-address sequencer
module nced_dispatch
    import nced_pkg::*;
(
    // Clock and reset
    input  wire logic              i_clock,
    input  wire logic              i_rst,
    // Function from the maintenance channel or CPU
    input  wire nced_req_s         i_req,
    // Nanocode word read at the current address
    input  wire logic [35:0]       i_word,
    // Sequence end, returns the sequencer to idle
    input  wire logic              i_seq_done,
    // Nanocode ROM address and status
    output logic [7:0]             o_addr,
    output logic                   o_busy,
    output logic                   o_forced,
    output logic                   o_parity_err,
    output nced_region_e           o_region,
    output logic                   o_dummy
);
    typedef enum logic [1:0] {NCED_ST_IDLE, NCED_ST_RUN} nced_state_e;

    nced_state_e  state;
    nced_state_e  next_state;
    logic [7:0]   addr;
    logic [7:0]   next_addr;
    logic         busy;
    logic         next_busy;
    logic         forced;
    logic         next_forced;
    logic         perr;
    logic         next_perr;
    nced_region_e region;
    logic         dummy;
    nced_region_e cls_region;
    logic         cls_dummy;
    logic [2:0]   start_code;
    logic [2:0]   next_start_code;
    logic [2:0]   held_type;
    logic [2:0]   next_held_type;
    logic [3:0]   held_rom;
    logic [3:0]   next_held_rom;
    logic [3:0]   held_cpu;
    logic [3:0]   next_held_cpu;
    logic         need_nano;
    nced_entry_e  entry;
    nced_word_s   word;

    assign word = nced_word_s'(i_word);

    // Decides whether a function runs nanocode and which entry it takes
    function automatic logic needs_nanocode(input nced_func_e f);
        case (f)
            NCED_FN_READ, NCED_FN_WRITE, NCED_FN_DEADSTART,
            NCED_FN_STATUS, NCED_FN_ECHO, NCED_FN_CPUREQ: needs_nanocode = 1'b1;
            default: needs_nanocode = 1'b0;
        endcase
    endfunction : needs_nanocode

    function automatic nced_entry_e entry_of(input nced_func_e f, input logic ok);
        case (f)
            NCED_FN_READ:      entry_of = ok ? NCED_EN_READ : NCED_EN_DREAD;
            NCED_FN_WRITE:     entry_of = ok ? NCED_EN_WRITE : NCED_EN_DWRITE;
            NCED_FN_DEADSTART: entry_of = NCED_EN_DEADSTART;
            NCED_FN_STATUS:    entry_of = NCED_EN_STATUS;
            NCED_FN_ECHO:      entry_of = NCED_EN_ECHO;
            NCED_FN_CPUREQ:    entry_of = NCED_EN_CPUREQ;
            default:           entry_of = NCED_EN_READ;
        endcase
    endfunction : entry_of

    function automatic logic even_ok(input logic [35:0] w);
        even_ok = ~^w;
    endfunction : even_ok

    always_comb begin
        need_nano = i_req.valid && needs_nanocode(i_req.func);
        entry     = entry_of(i_req.func, i_req.target_ok);
    end

    nced_region u_region (
        .i_addr   (next_addr),
        .o_region (cls_region),
        .o_dummy  (cls_dummy)
    );

    always_comb begin
        next_state      = state;
        next_addr       = addr;
        next_busy       = busy;
        next_forced     = 1'b0;
        next_perr       = perr;
        next_start_code = start_code;
        next_held_type  = held_type;
        next_held_rom   = held_rom;
        next_held_cpu   = held_cpu;
        case (state)
            NCED_ST_IDLE: begin
                // Functions without nanocode leave address and state alone
                if (need_nano) begin
                    next_start_code = 3'(entry);
                    next_addr       = NCED_ENTRY_BASE | {5'h00, 3'(entry)};
                    next_forced     = 1'b1;
                    next_busy       = 1'b1;
                    next_perr       = 1'b0;
                    next_held_type  = i_req.type_code_bits;
                    next_held_rom   = i_req.control_word_rom;
                    next_held_cpu   = i_req.cpu_func;
                    next_state      = NCED_ST_RUN;
                end
            end
            NCED_ST_RUN: begin
                if (!even_ok(i_word)) begin
                    next_perr = 1'b1;
                end
                if (i_seq_done) begin
                    next_state = NCED_ST_IDLE;
                    next_busy  = 1'b0;
                    next_addr  = NCED_RESET_ADDR;
                end else begin
                    case (word.sel)
                        NCED_SEL_ENTRY:  next_addr = NCED_ENTRY_BASE | {5'h00, start_code};
                        NCED_SEL_DEVICE: next_addr = {word.branch_field[7], held_type, held_rom};
                        NCED_SEL_CPU:    next_addr = {word.branch_field[7:4], held_cpu};
                        NCED_SEL_BRANCH: next_addr = word.branch_field;
                        default:         next_addr = word.branch_field;
                    endcase
                end
            end
            default: begin
                next_state = NCED_ST_IDLE;
                next_busy  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state      <= NCED_ST_IDLE;
            addr       <= NCED_RESET_ADDR;
            busy       <= 1'b0;
            forced     <= 1'b0;
            perr       <= 1'b0;
            start_code <= 3'h0;
            held_type  <= 3'h0;
            held_rom   <= 4'h0;
            held_cpu   <= 4'h0;
            region     <= NCED_R_NONE;
            dummy      <= 1'b0;
        end else begin
            state      <= next_state;
            addr       <= next_addr;
            busy       <= next_busy;
            forced     <= next_forced;
            perr       <= next_perr;
            start_code <= next_start_code;
            held_type  <= next_held_type;
            held_rom   <= next_held_rom;
            held_cpu   <= next_held_cpu;
            region     <= cls_region;
            dummy      <= cls_dummy;
        end
    end

    always_comb begin
        o_addr       = addr;
        o_busy       = busy;
        o_forced     = forced;
        o_parity_err = perr;
        o_region     = region;
        o_dummy      = dummy;
    end
endmodule : nced_dispatch

// *** nced_pkg.sv ***
// Package with constants and types for the nanocode entry dispatch block
package nced_pkg;
    localparam int NCED_ADDR_W    = 8;
    localparam int NCED_WORD_W    = 36;
    localparam int NCED_FUNC_W    = 4;
    localparam int NCED_BRANCH_LSB = 0;
    localparam int NCED_SEL_LSB   = 8;
    localparam int NCED_PAR_BIT   = 35;

    localparam logic [7:0] NCED_ENTRY_BASE = 8'h20;
    localparam logic [7:0] NCED_IO_RD_LO   = 8'h01;
    localparam logic [7:0] NCED_IO_RD_HI   = 8'h0a;
    localparam logic [7:0] NCED_REGF_RD    = 8'h1f;
    localparam logic [7:0] NCED_MAP_RD     = 8'h2f;
    localparam logic [7:0] NCED_AD_RD      = 8'h3f;
    localparam logic [7:0] NCED_SCAN_RD    = 8'h4f;
    localparam logic [7:0] NCED_CS_RD      = 8'h5f;
    localparam logic [7:0] NCED_MEM_RD_LO  = 8'h61;
    localparam logic [7:0] NCED_MEM_RD_HI  = 8'h69;
    localparam logic [7:0] NCED_CPU_RD_LO  = 8'h71;
    localparam logic [7:0] NCED_CPU_RD_HI  = 8'h7f;
    localparam logic [7:0] NCED_IO_WR_LO   = 8'h81;
    localparam logic [7:0] NCED_IO_WR_DHI  = 8'h83;
    localparam logic [7:0] NCED_IO_WR_HI   = 8'h8a;
    localparam logic [7:0] NCED_REGF_DWR   = 8'h9f;
    localparam logic [7:0] NCED_MAP_DWR    = 8'haf;
    localparam logic [7:0] NCED_AD_DWR     = 8'hbf;
    localparam logic [7:0] NCED_CPUREQ_LO  = 8'hc0;
    localparam logic [7:0] NCED_CPUREQ_HI  = 8'hcf;
    localparam logic [7:0] NCED_CS_WR      = 8'hdf;
    localparam logic [7:0] NCED_MEM_WR_LO  = 8'he1;
    localparam logic [7:0] NCED_MEM_WR_DHI = 8'he3;
    localparam logic [7:0] NCED_MEM_WR_HI  = 8'he9;
    localparam logic [7:0] NCED_CPU_WR_LO  = 8'hf4;
    localparam logic [7:0] NCED_CPU_WR_HI  = 8'hff;
    localparam logic [7:0] NCED_RESET_ADDR = 8'h00;

    // Maintenance channel function codes as presented to this block
    typedef enum logic [3:0] {
        NCED_FN_NONE, NCED_FN_READ, NCED_FN_WRITE, NCED_FN_DEADSTART,
        NCED_FN_STATUS, NCED_FN_ECHO, NCED_FN_CPUREQ, NCED_FN_CLEAR
    } nced_func_e;

    // Entry address low three bits, in fixed order 20..27
    typedef enum logic [2:0] {
        NCED_EN_READ, NCED_EN_WRITE, NCED_EN_DREAD, NCED_EN_DWRITE,
        NCED_EN_DEADSTART, NCED_EN_STATUS, NCED_EN_ECHO, NCED_EN_CPUREQ
    } nced_entry_e;

    // Next-address select held in word bits 8 and 9
    typedef enum logic [1:0] {
        NCED_SEL_ENTRY, NCED_SEL_DEVICE, NCED_SEL_CPU, NCED_SEL_BRANCH
    } nced_sel_e;

    typedef enum logic [3:0] {
        NCED_R_NONE, NCED_R_IO_RD, NCED_R_REGF_RD, NCED_R_ENTRY, NCED_R_MAP_RD,
        NCED_R_AD_RD, NCED_R_SCAN_RD, NCED_R_CS_RD, NCED_R_MEM_RD, NCED_R_CPU_RD,
        NCED_R_IO_WR, NCED_R_DUMMY_WR, NCED_R_CPUREQ, NCED_R_CS_WR, NCED_R_MEM_WR,
        NCED_R_CPU_WR
    } nced_region_e;

    typedef struct packed {
        logic       valid;
        nced_func_e func;
        logic       target_ok;
        logic [2:0] type_code_bits;
        logic [3:0] control_word_rom;
        logic [3:0] cpu_func;
    } nced_req_s;

    typedef struct packed {
        logic       parity;
        logic [24:0] ctrl;
        nced_sel_e  sel;
        logic [7:0] branch_field;
    } nced_word_s;
endpackage : nced_pkg

// *** nced_region.sv ***
// Classifier that maps a nanostore address to its sequence region
module nced_region
    import nced_pkg::*;
(
    // Address in, region and dummy flag out
    input  wire logic [7:0] i_addr,
    output nced_region_e    o_region,
    output logic            o_dummy
);
    function automatic logic in_rng(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction : in_rng

    always_comb begin
        o_region = NCED_R_NONE;
        o_dummy  = 1'b0;
        if (in_rng(i_addr, NCED_IO_RD_LO, NCED_IO_RD_HI)) begin
            o_region = NCED_R_IO_RD;
        end else if (i_addr == NCED_REGF_RD) begin
            o_region = NCED_R_REGF_RD;
        end else if (in_rng(i_addr, NCED_ENTRY_BASE, NCED_ENTRY_BASE + 8'h07)) begin
            o_region = NCED_R_ENTRY;
        end else if (i_addr == NCED_MAP_RD) begin
            o_region = NCED_R_MAP_RD;
        end else if (i_addr == NCED_AD_RD) begin
            o_region = NCED_R_AD_RD;
        end else if (i_addr == NCED_SCAN_RD) begin
            o_region = NCED_R_SCAN_RD;
        end else if (i_addr == NCED_CS_RD) begin
            o_region = NCED_R_CS_RD;
        end else if (in_rng(i_addr, NCED_MEM_RD_LO, NCED_MEM_RD_HI)) begin
            o_region = NCED_R_MEM_RD;
        end else if (in_rng(i_addr, NCED_CPU_RD_LO, NCED_CPU_RD_HI)) begin
            o_region = NCED_R_CPU_RD;
        end else if (in_rng(i_addr, NCED_IO_WR_LO, NCED_IO_WR_HI)) begin
            o_region = NCED_R_IO_WR;
            o_dummy  = (i_addr <= NCED_IO_WR_DHI);
        end else if (i_addr == NCED_REGF_DWR || i_addr == NCED_MAP_DWR || i_addr == NCED_AD_DWR) begin
            o_region = NCED_R_DUMMY_WR;
            o_dummy  = 1'b1;
        end else if (in_rng(i_addr, NCED_CPUREQ_LO, NCED_CPUREQ_HI)) begin
            o_region = NCED_R_CPUREQ;
        end else if (i_addr == NCED_CS_WR) begin
            o_region = NCED_R_CS_WR;
        end else if (in_rng(i_addr, NCED_MEM_WR_LO, NCED_MEM_WR_HI)) begin
            o_region = NCED_R_MEM_WR;
            o_dummy  = (i_addr <= NCED_MEM_WR_DHI);
        end else if (in_rng(i_addr, NCED_CPU_WR_LO, NCED_CPU_WR_HI)) begin
            o_region = NCED_R_CPU_WR;
        end
    end
endmodule : nced_region

// *** nced_assertions.sv ***
// Concurrent checks on the nanocode dispatch ports
module nced_assertions
    import nced_pkg::*;
(
    // Watched ports
    input wire logic         i_clock,
    input wire logic         i_rst,
    input wire nced_req_s    i_req,
    input wire logic [35:0]  i_word,
    input wire logic         i_seq_done,
    input wire logic [7:0]   o_addr,
    input wire logic         o_busy,
    input wire logic         o_forced,
    input wire logic         o_parity_err,
    input wire nced_region_e o_region,
    input wire logic         o_dummy
);
    nced_req_s  cap;
    logic       nano;
    logic [2:0] code;
    logic [7:0] ent;
    // Fields frozen once busy, matching what the sequencer holds
    always_ff @(posedge i_clock) begin
        if (!o_busy) begin
            cap <= i_req;
        end
        // Forced entry of the running sequence, already checked by entry_addr_a
        if (o_forced) begin
            ent <= o_addr;
        end
    end
    always_comb begin
        nano = i_req.func inside {NCED_FN_READ, NCED_FN_WRITE, NCED_FN_DEADSTART,
                                  NCED_FN_STATUS, NCED_FN_ECHO, NCED_FN_CPUREQ};
        case (i_req.func)
            NCED_FN_READ:      code = i_req.target_ok ? 3'h0 : 3'h2;
            NCED_FN_WRITE:     code = i_req.target_ok ? 3'h1 : 3'h3;
            NCED_FN_DEADSTART: code = 3'h4;
            NCED_FN_STATUS:    code = 3'h5;
            NCED_FN_ECHO:      code = 3'h6;
            default:           code = 3'h7;
        endcase
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    sequence take_s;
        !o_busy && i_req.valid && nano;
    endsequence
    sequence entry_s;
        o_forced && o_busy && o_region == NCED_R_ENTRY;
    endsequence
    entry_addr_a: assert property (take_s |=> entry_s ##0 o_addr == {5'h04, $past(code)})
        else $error("entry address wrong");
    forced_pulse_a: assert property (o_forced |=> !o_forced)
        else $error("forced not a single pulse");
    no_nanocode_a: assert property (!o_busy && !(i_req.valid && nano) |=> !o_busy && !o_forced)
        else $error("sequence started without nanocode function");
    sel_entry_a: assert property (o_busy && !i_seq_done && i_word[9:8] == 2'b00 |=> o_addr == ent)
        else $error("select 00 not to entry block");
    sel_device_a: assert property (o_busy && !i_seq_done && i_word[9:8] == 2'b01
        |=> o_addr == {$past(i_word[7]), cap.type_code_bits, cap.control_word_rom})
        else $error("device offset address wrong");
    sel_cpu_a: assert property (o_busy && !i_seq_done && i_word[9:8] == 2'b10
        |=> o_addr == {$past(i_word[7:4]), cap.cpu_func})
        else $error("cpu function address wrong");
    sel_branch_a: assert property (o_busy && !i_seq_done && i_word[9:8] == 2'b11 |=> o_addr == $past(i_word[7:0]))
        else $error("branch address wrong");
    parity_flag_a: assert property (o_busy && !i_seq_done && ^i_word |=> o_parity_err)
        else $error("odd parity not flagged");
    dummy_flag_a: assert property (o_dummy == (o_addr inside {[8'h81:8'h83], 8'h9f, 8'haf, 8'hbf, [8'he1:8'he3]}))
        else $error("dummy flag wrong");
    idle_return_a: assert property (o_busy && i_seq_done |=> !o_busy && o_addr == 8'h00)
        else $error("no return to idle");
endmodule : nced_assertions

// *** nced_rom_model.sv ***
// Nanocode ROM model answering the dispatch address combinationally
module nced_rom_model
    import nced_pkg::*;
(
    // Address in, parity fault injection
    input  wire logic [7:0] i_addr,
    input  wire logic       i_bad_par,
    // Word at that address
    output logic [35:0]     o_word
);
    logic [9:0] sb;
    always_comb begin
        case (i_addr)
            8'h20:   sb = {NCED_SEL_DEVICE, 8'h00};
            8'h21:   sb = {NCED_SEL_DEVICE, 8'h80};
            8'h22:   sb = {NCED_SEL_BRANCH, NCED_REGF_RD};
            8'h23:   sb = {NCED_SEL_BRANCH, NCED_REGF_DWR};
            8'h24:   sb = {NCED_SEL_BRANCH, NCED_SCAN_RD};
            8'h25:   sb = {NCED_SEL_BRANCH, NCED_CS_RD};
            8'h26:   sb = {NCED_SEL_BRANCH, NCED_AD_RD};
            8'h27:   sb = {NCED_SEL_CPU, NCED_CPUREQ_LO};
            // Control store read steps back to its entry, so select 00 gets exercised
            8'h5f:   sb = {NCED_SEL_ENTRY, 8'h00};
            // Non-entry words other than 5f park on themselves until the bench ends the run
            default: sb = {NCED_SEL_BRANCH, i_addr};
        endcase
        o_word = {26'h0, sb};
        o_word[35] = ^o_word[34:0] ^ i_bad_par;
    end
endmodule : nced_rom_model

// *** tb.sv ***
// Self-checking bench for the nanocode entry dispatcher
module tb
    import nced_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic         i_clock;
    logic         i_rst;
    nced_req_s    req;
    logic [35:0]  word;
    logic         seq_done;
    logic         bad_par;
    logic [7:0]   addr;
    logic         busy;
    logic         forced;
    logic         perr;
    nced_region_e region;
    logic         dummy;
    int           bad_count = 0;
    int           num_checks = 0;
    nced_dispatch uut (.i_clock(i_clock), .i_rst(i_rst), .i_req(req), .i_word(word), .i_seq_done(seq_done),
        .o_addr(addr), .o_busy(busy), .o_forced(forced), .o_parity_err(perr), .o_region(region), .o_dummy(dummy));
    nced_rom_model rom (.i_addr(addr), .i_bad_par(bad_par), .o_word(word));
    initial begin
        i_clock = 1'b0;
        forever #2.5 i_clock = ~i_clock;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic run(input nced_func_e f, input logic tok, input logic [6:0] off, input logic [7:0] e_ent,
                       input logic [7:0] e_nxt);
        @(posedge i_clock);
        req <= '{1'b1, f, tok, off[6:4], off[3:0], 4'h5};
        @(posedge i_clock);
        req.valid <= 1'b0;
        #1;
        chk("entry", e_ent, addr);
        chk("forced", 8'h01, {7'h0, forced});
        chk("region", {4'h0, NCED_R_ENTRY}, {4'h0, region});
        @(posedge i_clock);
        #1;
        chk("next", e_nxt, addr);
        chk("dummy", {7'h0, e_nxt == 8'h9f}, {7'h0, dummy});
        @(posedge i_clock);
        seq_done <= 1'b1;
        #1;
        chk("third", (e_nxt == NCED_CS_RD) ? e_ent : e_nxt, addr);
        @(posedge i_clock);
        seq_done <= 1'b0;
        #1;
        chk("idle addr", 8'h00, addr);
        chk("busy", 8'h00, {7'h0, busy});
    endtask : run
    task automatic t_entries();
        run(NCED_FN_READ, 1'b1, 7'h61, 8'h20, 8'h61);
        run(NCED_FN_WRITE, 1'b1, 7'h04, 8'h21, 8'h84);
        run(NCED_FN_READ, 1'b0, 7'h61, 8'h22, 8'h1f);
        run(NCED_FN_WRITE, 1'b0, 7'h04, 8'h23, 8'h9f);
        run(NCED_FN_DEADSTART, 1'b1, 7'h00, 8'h24, 8'h4f);
        run(NCED_FN_STATUS, 1'b1, 7'h00, 8'h25, 8'h5f);
        run(NCED_FN_ECHO, 1'b1, 7'h00, 8'h26, 8'h3f);
        run(NCED_FN_CPUREQ, 1'b1, 7'h00, 8'h27, 8'hc5);
    endtask : t_entries
    task automatic t_ignored();
        // A write held up during a read must neither restart nor queue
        @(posedge i_clock);
        req <= '{1'b1, NCED_FN_CLEAR, 1'b1, 3'h6, 4'h1, 4'h5};
        @(posedge i_clock);
        req.func <= NCED_FN_NONE;
        @(posedge i_clock);
        #1;
        chk("no start", 8'h00, {6'h0, busy, forced});
        @(posedge i_clock);
        req.func <= NCED_FN_READ;
        @(posedge i_clock);
        req.func <= NCED_FN_WRITE;
        @(posedge i_clock);
        #1;
        chk("busy refuse", 8'h61, addr);
        chk("refuse forced", 8'h00, {7'h0, forced});
        @(posedge i_clock);
        req.valid <= 1'b0;
        seq_done <= 1'b1;
        @(posedge i_clock);
        seq_done <= 1'b0;
        @(posedge i_clock);
        #1;
        chk("after refuse", 8'h00, {6'h0, busy, forced});
    endtask : t_ignored
    task automatic t_parity();
        bad_par <= 1'b1;
        run(NCED_FN_ECHO, 1'b1, 7'h00, 8'h26, 8'h3f);
        bad_par <= 1'b0;
        chk("parity set", 8'h01, {7'h0, perr});
        run(NCED_FN_STATUS, 1'b1, 7'h00, 8'h25, 8'h5f);
        chk("parity clear", 8'h00, {7'h0, perr});
    endtask : t_parity
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude
    initial begin
        i_rst = 1'b1;
        req = '0;
        seq_done = 1'b0;
        bad_par = 1'b0;
        repeat (12) @(posedge i_clock);
        i_rst <= 1'b0;
        t_entries();
        t_ignored();
        t_parity();
        conclude();
    end
    // Whole run is about 70 cycles; this span of 4000 cycles is far beyond it
    initial begin
        #20000;
        bad_count++;
        conclude();
    end
endmodule : tb
bind nced_dispatch nced_assertions chk_i (.i_clock, .i_rst, .i_req, .i_word, .i_seq_done, .o_addr, .o_busy,
    .o_forced, .o_parity_err, .o_region, .o_dummy);
